// *** include/fbx_consts.vh ***
// constants for the fieldbus data exchange block
// assumes inclusion by the design file and the bench only
`ifndef FBX_CONSTS_VH
`define FBX_CONSTS_VH
// register indices; byte address is index times four
`define FBX_IDX_OUT_CNT      10'h3E8
`define FBX_IDX_OUT_SIZE     10'h3EB
`define FBX_IDX_IN_CNT       10'h3EF
`define FBX_IDX_IN_OFS       10'h3F0
`define FBX_IDX_IN_START     10'h3F1
`define FBX_IDX_IN_SIZE      10'h3F2
`define FBX_IDX_SYNC_SEL     10'h3F8
`define FBX_IDX_HOLD_SEL     10'h3F9
`define FBX_IDX_CTRL         10'h3FC
`define FBX_IDX_STATUS       10'h3FD
`define FBX_IDX_OUT_DATA     10'h3FE
`define FBX_IDX_IN_DATA      10'h3FF
// field values
`define FBX_SETTING_RST      16'h0000
`define FBX_SYNC_ON          16'h0001
`define FBX_HOLD_ON          16'h0001
`define FBX_ZERO16           16'h0000
`define FBX_ZERO32           32'h0000_0000
// control bits
`define FBX_CTRL_RUN         0
`define FBX_CTRL_DL          1
`define FBX_CTRL_RESTART     2
// autonomous timer reload; starts come at least this plus one clocks apart
`define FBX_AUTO_PERIOD      16'h0100
`define FBX_ONE16            16'h0001
`endif

// *** verilog/fbx_bridge.v ***
// fieldbus data exchange bridge: wishbone registers, run control,
// sync/autonomous cycle triggering, input buffering.
// assumes a fieldbus engine that starts on a pulse and reports done.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "fbx_consts.vh"

// Contract
// - on run drop, hold or clear slave outputs per hold setting
// - sync select word: 0001 synchronous, zero autonomous
// - synchronous mode tries a new bus cycle at each host refresh
// - sync: if previous cycle busy at refresh, skip and retry next; code keeps the refresh pending and starts once the engine is free
// - autonomous mode starts cycles on own schedule
// - autonomous: latest completed cycle inputs buffered for host
// - all fieldbus activity suspended during configuration download
// - settings reset to 0000, take effect only after unit restart
module fbx_bridge
(
  // system
  input  wire        CLK_I,
  input  wire        SRST_I,
  input  wire        CE_I,
  // wishbone slave
  input  wire        CYC_I,
  input  wire        STB_I,
  input  wire        WE_I,
  input  wire [11:0] ADR_I,
  input  wire [3:0]  SEL_I,
  input  wire [31:0] DAT_I,
  output reg  [31:0] DAT_O,
  output reg         ACK_O,
  // host refresh pin, asynchronous
  input  wire        REFRESH_I,
  // fieldbus engine
  output reg         CYCLE_START_O,
  input  wire        CYCLE_DONE_I,
  input  wire        CYCLE_BUSY_I,
  input  wire [15:0] CYCLE_IN_DATA_I,
  output reg  [15:0] SLAVE_OUT_DATA_O,
  output reg         BUS_ENABLE_O,
  // input stream towards host
  output wire        IN_VALID_O,
  input  wire        IN_READY_I,
  output wire [15:0] IN_DATA_O
);

  function [15:0] fbx_merge;
    input [15:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    begin
      fbx_merge = {sel[1] ? dat[15:8] : old[15:8],
                   sel[0] ? dat[7:0]  : old[7:0]};
    end
  endfunction

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_DL   = 3'b100;

  // pending settings, written by software
  reg  [15:0] out_cnt_reg;
  reg  [15:0] out_size_reg;
  reg  [15:0] in_cnt_reg;
  reg  [15:0] in_ofs_reg;
  reg  [15:0] in_start_reg;
  reg  [15:0] in_size_reg;
  reg  [15:0] sync_sel_reg;
  reg  [15:0] hold_sel_reg;
  // active copies, latched at restart
  reg  [15:0] act_sync_reg;
  reg  [15:0] act_hold_reg;
  reg         run_reg;
  reg         dl_reg;
  reg  [15:0] out_data_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg         pend_reg;
  reg         run_q_reg;
  reg  [15:0] auto_cnt_reg;
  reg  [2:0]  ref_sync_reg;
  reg         ref_lvl_reg;
  reg  [15:0] last_in_reg;
  // two-entry buffer
  reg  [15:0] buf_mem_reg [0:1];
  reg         wr_ptr_reg;
  reg         rd_ptr_reg;
  reg  [1:0]  cnt_reg;

  wire        wb_req  = CYC_I & STB_I & ~ACK_O;
  wire        wb_wr   = wb_req & WE_I;
  wire [9:0]  idx     = ADR_I[11:2];
  wire        sync_m  = (act_sync_reg == `FBX_SYNC_ON);
  wire        running = (state_reg == ST_RUN);
  wire        ref_new = (ref_sync_reg[2] == ref_sync_reg[1]) &
                        (ref_sync_reg[1] != ref_lvl_reg);
  wire        ref_evt = ref_new & ref_sync_reg[1];
  wire        auto_due = (auto_cnt_reg == `FBX_ZERO16);
  wire        buf_full = (cnt_reg == 2'b10);
  // a word that completes after run drops is still kept
  wire        buf_push = CYCLE_DONE_I & ~buf_full;
  wire        buf_pop  = IN_VALID_O & IN_READY_I;
  // room for the next cycle's word, counting a word landing now
  wire        buf_room = ~buf_full &
                         ~((cnt_reg == 2'b01) & CYCLE_DONE_I & ~buf_pop);
  // the pulse itself blocks: the engine shows busy one cycle later
  wire        start_ok = running & ~CYCLE_BUSY_I & buf_room &
                         ~CYCLE_START_O;
  wire        want     = sync_m ? (pend_reg | ref_evt) : auto_due;
  wire        restart  = wb_wr & (idx == `FBX_IDX_CTRL) &
                         SEL_I[0] & DAT_I[`FBX_CTRL_RESTART];

  assign IN_VALID_O = (cnt_reg != 2'b00);
  assign IN_DATA_O  = buf_mem_reg[rd_ptr_reg];

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (dl_reg)
          state_next = ST_DL;
        else if (run_reg)
          state_next = ST_RUN;
      end
      ST_RUN:
      begin
        if (dl_reg)
          state_next = ST_DL;
        else if (!run_reg)
          state_next = ST_IDLE;
      end
      ST_DL:
      begin
        if (!dl_reg)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      out_cnt_reg   <= `FBX_SETTING_RST;
      out_size_reg  <= `FBX_SETTING_RST;
      in_cnt_reg    <= `FBX_SETTING_RST;
      in_ofs_reg    <= `FBX_SETTING_RST;
      in_start_reg  <= `FBX_SETTING_RST;
      in_size_reg   <= `FBX_SETTING_RST;
      sync_sel_reg  <= `FBX_SETTING_RST;
      hold_sel_reg  <= `FBX_SETTING_RST;
      act_sync_reg  <= `FBX_SETTING_RST;
      act_hold_reg  <= `FBX_SETTING_RST;
      run_reg       <= 1'b0;
      dl_reg        <= 1'b0;
      out_data_reg  <= `FBX_ZERO16;
      ACK_O         <= 1'b0;
      DAT_O         <= `FBX_ZERO32;
    end
    else if (CE_I)
    begin
      ACK_O <= wb_req;
      DAT_O <= `FBX_ZERO32;
      if (restart)
      begin
        act_sync_reg <= sync_sel_reg;
        act_hold_reg <= hold_sel_reg;
      end
      if (wb_wr)
      begin
        case (idx)
          `FBX_IDX_OUT_CNT:
            out_cnt_reg <= fbx_merge(out_cnt_reg, DAT_I, SEL_I);
          `FBX_IDX_OUT_SIZE:
            out_size_reg <= fbx_merge(out_size_reg, DAT_I, SEL_I);
          `FBX_IDX_IN_CNT:
            in_cnt_reg <= fbx_merge(in_cnt_reg, DAT_I, SEL_I);
          `FBX_IDX_IN_OFS:
            in_ofs_reg <= fbx_merge(in_ofs_reg, DAT_I, SEL_I);
          `FBX_IDX_IN_START:
            in_start_reg <= fbx_merge(in_start_reg, DAT_I, SEL_I);
          `FBX_IDX_IN_SIZE:
            in_size_reg <= fbx_merge(in_size_reg, DAT_I, SEL_I);
          `FBX_IDX_SYNC_SEL:
            sync_sel_reg <= fbx_merge(sync_sel_reg, DAT_I, SEL_I);
          `FBX_IDX_HOLD_SEL:
            hold_sel_reg <= fbx_merge(hold_sel_reg, DAT_I, SEL_I);
          `FBX_IDX_OUT_DATA:
            out_data_reg <= fbx_merge(out_data_reg, DAT_I, SEL_I);
          `FBX_IDX_CTRL:
          begin
            if (SEL_I[0])
            begin
              run_reg <= DAT_I[`FBX_CTRL_RUN];
              dl_reg  <= DAT_I[`FBX_CTRL_DL];
            end
          end
          default:
            out_data_reg <= out_data_reg;
        endcase
      end
      else if (wb_req)
      begin
        case (idx)
          `FBX_IDX_OUT_CNT:  DAT_O <= {`FBX_ZERO16, out_cnt_reg};
          `FBX_IDX_OUT_SIZE: DAT_O <= {`FBX_ZERO16, out_size_reg};
          `FBX_IDX_IN_CNT:   DAT_O <= {`FBX_ZERO16, in_cnt_reg};
          `FBX_IDX_IN_OFS:   DAT_O <= {`FBX_ZERO16, in_ofs_reg};
          `FBX_IDX_IN_START: DAT_O <= {`FBX_ZERO16, in_start_reg};
          `FBX_IDX_IN_SIZE:  DAT_O <= {`FBX_ZERO16, in_size_reg};
          `FBX_IDX_SYNC_SEL: DAT_O <= {`FBX_ZERO16, sync_sel_reg};
          `FBX_IDX_HOLD_SEL: DAT_O <= {`FBX_ZERO16, hold_sel_reg};
          `FBX_IDX_OUT_DATA: DAT_O <= {`FBX_ZERO16, out_data_reg};
          `FBX_IDX_IN_DATA:  DAT_O <= {`FBX_ZERO16, last_in_reg};
          `FBX_IDX_CTRL:
            DAT_O <= {29'h0000_0000, 1'b0, dl_reg, run_reg};
          `FBX_IDX_STATUS:
            DAT_O <= {24'h00_0000, 1'b0, cnt_reg, pend_reg,
                      act_hold_reg[0], act_sync_reg[0], state_reg[2],
                      state_reg[1]};
          default:
            DAT_O <= `FBX_ZERO32;
        endcase
      end
    end
  end

  // refresh pin: three flops, change taken when second and third agree
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      ref_sync_reg <= 3'b000;
      ref_lvl_reg  <= 1'b0;
    end
    else if (CE_I)
    begin
      ref_sync_reg <= {ref_sync_reg[1:0], REFRESH_I};
      if (ref_new)
        ref_lvl_reg <= ref_sync_reg[1];
    end
  end

  // run state, bus enable and slave output hold/clear
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      state_reg        <= ST_IDLE;
      run_q_reg        <= 1'b0;
      BUS_ENABLE_O     <= 1'b0;
      SLAVE_OUT_DATA_O <= `FBX_ZERO16;
    end
    else if (CE_I)
    begin
      state_reg    <= state_next;
      run_q_reg    <= run_reg;
      BUS_ENABLE_O <= (state_next == ST_RUN);
      if (running && run_reg)
        SLAVE_OUT_DATA_O <= out_data_reg;
      else if (run_q_reg && !run_reg &&
               act_hold_reg != `FBX_HOLD_ON)
        SLAVE_OUT_DATA_O <= `FBX_ZERO16;
    end
  end

  // sync trigger memory; a refresh met by a busy engine is kept
  always @(posedge CLK_I)
  begin
    if (SRST_I)
      pend_reg <= 1'b0;
    else if (CE_I)
    begin
      if (!running || !sync_m)
        pend_reg <= 1'b0;
      else if (start_ok)
        pend_reg <= 1'b0;
      else if (ref_evt)
        pend_reg <= 1'b1;
    end
  end

  // autonomous timer; waits at zero until a start can go out
  always @(posedge CLK_I)
  begin
    if (SRST_I)
      auto_cnt_reg <= `FBX_ZERO16;
    else if (CE_I)
    begin
      if (!running || sync_m)
        auto_cnt_reg <= `FBX_ZERO16;
      else if (!auto_due)
        auto_cnt_reg <= auto_cnt_reg - `FBX_ONE16;
      else if (start_ok)
        auto_cnt_reg <= `FBX_AUTO_PERIOD;
    end
  end

  // start pulse and newest completed input word
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      CYCLE_START_O <= 1'b0;
      last_in_reg   <= `FBX_ZERO16;
    end
    else if (CE_I)
    begin
      CYCLE_START_O <= want & start_ok;
      if (buf_push)
        last_in_reg <= CYCLE_IN_DATA_I;
    end
  end

  // two-entry input buffer; new cycles wait while it is full
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      wr_ptr_reg     <= 1'b0;
      rd_ptr_reg     <= 1'b0;
      cnt_reg        <= 2'b00;
      buf_mem_reg[0] <= `FBX_ZERO16;
      buf_mem_reg[1] <= `FBX_ZERO16;
    end
    else if (CE_I)
    begin
      if (buf_push)
      begin
        buf_mem_reg[wr_ptr_reg] <= CYCLE_IN_DATA_I;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (buf_pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (buf_push && !buf_pop)
        cnt_reg <= cnt_reg + 2'b01;
      else if (buf_pop && !buf_push)
        cnt_reg <= cnt_reg - 2'b01;
    end
  end

endmodule // fbx_bridge

// *** tb/fbx_bridge_chk.sv ***
// port-level assertions for the fieldbus exchange bridge
// assumes CE_I held high; bound to every fbx_bridge
`timescale 1ns/1ps
module fbx_chk
(
  // clock and reset
  input wire        CLK_I,
  input wire        SRST_I,
  // register bus
  input wire        CYC_I,
  input wire        STB_I,
  input wire        ACK_O,
  input wire [31:0] DAT_O,
  // engine side
  input wire        CYCLE_START_O,
  input wire        CYCLE_BUSY_I,
  input wire        CYCLE_DONE_I,
  input wire [15:0] CYCLE_IN_DATA_I,
  input wire        BUS_ENABLE_O,
  // input stream
  input wire        IN_VALID_O,
  input wire        IN_READY_I,
  input wire [15:0] IN_DATA_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SRST_I);

  a_ack_next: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack late");
  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack too long");
  a_dat_idle: assert property (!ACK_O |-> DAT_O == 32'h0000_0000)
    else $error("read data not idle");
  a_start_free: assert property (
    CYCLE_START_O |-> !$past(CYCLE_BUSY_I))
    else $error("start while busy");
  a_start_pulse: assert property (
    CYCLE_START_O |=> !CYCLE_START_O)
    else $error("start not a pulse");
  a_start_run: assert property (
    !BUS_ENABLE_O && !$past(BUS_ENABLE_O) |-> !CYCLE_START_O)
    else $error("start while stopped");
  a_push_done: assert property (
    CYCLE_DONE_I && !IN_VALID_O |=>
    IN_VALID_O && IN_DATA_O == $past(CYCLE_IN_DATA_I))
    else $error("done data not buffered");
  a_stream_hold: assert property (
    IN_VALID_O && !IN_READY_I |=> IN_VALID_O && $stable(IN_DATA_O))
    else $error("stalled word lost");
  a_reset_quiet: assert property (disable iff (1'b0)
    SRST_I |=> !ACK_O && !CYCLE_START_O && !BUS_ENABLE_O && !IN_VALID_O)
    else $error("outputs active in reset");
endmodule // fbx_chk

bind fbx_bridge fbx_chk chk_u (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .DAT_O(DAT_O),
  .CYCLE_START_O(CYCLE_START_O), .CYCLE_BUSY_I(CYCLE_BUSY_I),
  .CYCLE_DONE_I(CYCLE_DONE_I), .CYCLE_IN_DATA_I(CYCLE_IN_DATA_I),
  .BUS_ENABLE_O(BUS_ENABLE_O), .IN_VALID_O(IN_VALID_O),
  .IN_READY_I(IN_READY_I), .IN_DATA_O(IN_DATA_O));

// *** tb/fbx_engine_model.sv ***
// fieldbus engine stand-in: busy len_i+1 clocks per start
// assumes start is a one-cycle pulse; starts while busy ignored
`timescale 1ns/1ps
module fbx_engine_model
(
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // bridge side
  input  wire        start_i,
  input  wire [7:0]  len_i,
  output reg         busy_o,
  output reg         done_o,
  output reg  [15:0] data_o
);
  reg [7:0]  cnt_reg;
  reg [15:0] seq_reg;

  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    // toggles outside done so stale data never matches
    data_o <= ~data_o;
    if (rst_i)
    begin
      busy_o  <= 1'b0;
      cnt_reg <= 8'h00;
      seq_reg <= 16'hA000;
      data_o  <= 16'h0000;
    end
    else if (busy_o)
    begin
      cnt_reg <= cnt_reg - 8'h01;
      if (cnt_reg == 8'h00)
      begin
        busy_o  <= 1'b0;
        done_o  <= 1'b1;
        data_o  <= seq_reg;
        seq_reg <= seq_reg + 16'h0001;
      end
    end
    else if (start_i)
    begin
      busy_o  <= 1'b1;
      cnt_reg <= len_i;
    end
  end
endmodule // fbx_engine_model

// *** tb/test_fieldbus_plc_data_exchange.sv ***
// self-checking bench for the fieldbus exchange bridge
// assumes the engine stand-in and the bound checker
`timescale 1ns/1ps
`include "fbx_consts.vh"
module test_fieldbus_plc_data_exchange;
  reg         clk = 1'b0;
  reg         srst = 1'b1;
  reg         cyc = 1'b0;
  reg         stb = 1'b0;
  reg         we = 1'b0;
  reg         refresh = 1'b0;
  reg         ready = 1'b0;
  reg  [3:0]  sel = 4'hF;
  reg  [11:0] adr = 12'h000;
  reg  [31:0] wdat = 32'h0000_0000;
  reg  [31:0] rd;
  reg  [7:0]  len = 8'h04;
  reg  [79:0] ids;
  reg  [15:0] q [$];
  wire [31:0] rdat;
  wire [15:0] cin, sout, idata;
  wire        ack, start, done, busy, en, ivalid;
  integer     errors = 0;
  integer     comparisons = 0;
  integer     starts = 0;
  integer     s0;
  integer     i;

  always #20 clk = ~clk;

  fbx_bridge dut_u (.CLK_I(clk), .SRST_I(srst), .CE_I(1'b1), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat),
    .DAT_O(rdat), .ACK_O(ack), .REFRESH_I(refresh),
    .CYCLE_START_O(start), .CYCLE_DONE_I(done), .CYCLE_BUSY_I(busy),
    .CYCLE_IN_DATA_I(cin), .SLAVE_OUT_DATA_O(sout), .BUS_ENABLE_O(en),
    .IN_VALID_O(ivalid), .IN_READY_I(ready), .IN_DATA_O(idata));

  fbx_engine_model eng_u (.clk_i(clk), .rst_i(srst), .start_i(start),
    .len_i(len), .busy_o(busy), .done_o(done), .data_o(cin));

  task automatic chk(input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  end
  endtask

  // one classic cycle; values read here are those sampled at the edge
  task wb(input w, input [9:0] idx, input [31:0] d);
    integer n;
  begin
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20)
    begin
      n = n + 1;
      @(posedge clk);
    end
    if (n == 20)
      chk(32'h0000_0000, 32'h0000_0001);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  end
  endtask

  task pulse;
  begin
    refresh <= 1'b1;
    repeat (4) @(posedge clk);
    refresh <= 1'b0;
    repeat (6) @(posedge clk);
  end
  endtask

  task print_verdict;
  begin
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  always @(posedge clk)
  begin
    if (start === 1'b1)
      starts <= starts + 1;
    if (done === 1'b1)
      q.push_back(cin);
    if (ivalid === 1'b1 && ready === 1'b1)
      chk(idata, q.pop_front());
  end

  initial
  begin
    #400000;
    errors = errors + 1;
    print_verdict;
  end

  initial
  begin
    ids = {`FBX_IDX_OUT_CNT, `FBX_IDX_OUT_SIZE, `FBX_IDX_IN_CNT,
      `FBX_IDX_IN_OFS, `FBX_IDX_IN_START, `FBX_IDX_IN_SIZE,
      `FBX_IDX_SYNC_SEL, `FBX_IDX_HOLD_SEL};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // bit0 clear keeps autonomous mode and output clear
    for (i = 0; i < 8; i = i + 1)
    begin
      wb(1'b0, ids[i*10 +: 10], 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      wb(1'b1, ids[i*10 +: 10], 32'h0000_5A5A);
      wb(1'b0, ids[i*10 +: 10], 32'h0000_0000);
      chk(rd, 32'h0000_5A5A);
    end
    wb(1'b1, 10'h000, 32'h0000_FFFF);
    wb(1'b0, 10'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    s0 = starts;
    wb(1'b1, `FBX_IDX_CTRL, 32'h0000_0005);
    repeat (800) @(posedge clk);
    chk(starts - s0, 2);
    chk(en, 1'b1);
    wb(1'b1, `FBX_IDX_IN_DATA, 32'h0000_0000);
    wb(1'b0, `FBX_IDX_IN_DATA, 32'h0000_0000);
    chk(rd, q[1]);
    ready <= 1'b1;
    wb(1'b1, `FBX_IDX_OUT_DATA, 32'h0000_5A5A);
    sel <= 4'h1;
    wb(1'b1, `FBX_IDX_OUT_DATA, 32'h0000_00C3);
    sel <= 4'hF;
    repeat (2) @(posedge clk);
    chk(sout, 16'h5AC3);
    wb(1'b1, `FBX_IDX_CTRL, 32'h0000_0000);
    repeat (4) @(posedge clk);
    chk(sout, 16'h0000);
    chk(en, 1'b0);
    wb(1'b1, `FBX_IDX_SYNC_SEL, 32'h0000_0001);
    wb(1'b1, `FBX_IDX_HOLD_SEL, 32'h0000_0001);
    wb(1'b0, `FBX_IDX_STATUS, 32'h0000_0000);
    chk(rd[3:2], 2'b00);
    wb(1'b1, `FBX_IDX_CTRL, 32'h0000_0005);
    wb(1'b0, `FBX_IDX_STATUS, 32'h0000_0000);
    chk(rd[3:2], 2'b11);
    wb(1'b1, `FBX_IDX_CTRL, 32'h0000_0000);
    repeat (4) @(posedge clk);
    chk(sout, 16'h5AC3);
    wb(1'b1, `FBX_IDX_CTRL, 32'h0000_0001);
    s0 = starts;
    repeat (300) @(posedge clk);
    chk(starts - s0, 0);
    pulse;
    chk(starts - s0, 1);
    len <= 8'h3C;
    pulse;
    chk(starts - s0, 2);
    pulse;
    repeat (10) @(posedge clk);
    chk(starts - s0, 2);
    repeat (60) @(posedge clk);
    chk(starts - s0, 3);
    len <= 8'h04;
    repeat (70) @(posedge clk);
    wb(1'b1, `FBX_IDX_CTRL, 32'h0000_0003);
    s0 = starts;
    pulse;
    repeat (20) @(posedge clk);
    chk(starts - s0, 0);
    print_verdict;
  end
endmodule // test_fieldbus_plc_data_exchange
